/* File: shared/ssim_pkg.sv */
// Shared constants for the synchronous serial port, I2C master transmit side
package ssim_pkg;

  // Clock and default bit rate
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned I2C_DEFAULT_HZ = 100_000;
  // One bit is four quarter periods; divider reloads at quarter - 1
  localparam int unsigned QTR_CYCLES = CLK_HZ / (4 * I2C_DEFAULT_HZ);

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_STATUS = 12'h18f;
  localparam logic [11:0] IDX_CTRL = 12'h190;
  localparam logic [11:0] IDX_IRQ = 12'h191;
  localparam logic [11:0] IDX_BUF = 12'h192;
  localparam logic [11:0] IDX_BAUD = 12'h193;

  // Status register fields
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_STOP = 4;
  localparam int STAT_START = 3;
  localparam int STAT_RW = 2;
  localparam int STAT_BF = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_SPI = 4;
  localparam int CTRL_EN = 5;
  localparam int CTRL_WRITE_COLLISION_FLAG = 7;

  // Event register fields
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_ACK = 1;

  // Baud reset value and bit counts
  localparam logic [7:0] BAUD_RST = 8'(QTR_CYCLES - 1);
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // Quarter positions within one bit
  localparam logic [1:0] Q0 = 2'h0;
  localparam logic [1:0] Q1 = 2'h1;
  localparam logic [1:0] Q2 = 2'h2;
  localparam logic [1:0] Q3 = 2'h3;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_RESTART, ST_STOP, ST_BYTE, ST_HOLD, ST_SPI
  } ssim_state_t;

endpackage

/* File: rtl/ssim_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for pin inputs
module ssim_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage, read only by the second
  logic [W-1:0] meta_q;

  // Both stages reset to the idle pin level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/ssim_top.sv */
// Contract
// R1: buffer write sets full, eight shifted clears
// R2: write while shifting sets collision, discarded
// R3: software clears collision flag itself
// R4: ninth-bit acknowledge stored, 1 means none
// R5: start request makes start, then flag
// R6: software clears event flag each time
// R7: start hold time before next operation
// R8: buffer write starts shifting, MSB first
// R9: flag set after ninth clock
// R10: stop request makes stop, auto-cleared
// R11: restart request makes restart, auto-cleared
// R12: flag set after stop or restart
// R13: after byte, clock held low, SDA free
// R14: SPI sample phase: end or middle
// R15: sample phase clear as SPI slave
// R16: I2C sample phase selects slew control
// R17: SPI clock edge selects launch edge
// R18: data/address bit reserved in master
// R19: stop-seen bit reads last stop condition
// R20: SPI bit counter zeroed by select/enable
// R21: SPI slave with edge set uses select
// R22: start request initiates start, auto-cleared
// R23: other status flags are read-only
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module ssim_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pin: open drain in I2C, push-pull clock in SPI
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Data pin: open drain in I2C, data out in SPI
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // SPI data in and slave select
  input wire logic sdi_i,
  input wire logic ss_n_i,
  // Pad controls
  output logic slew_ctrl_en,
  output logic smbus_in_en
);

  // Byte address of a register index
  function automatic logic [11:0] addr_of(input logic [11:0] idx);
    addr_of = {idx[9:0], 2'b00};
  endfunction

  // Synchronised pins
  logic scl_s, sda_s, sdi_s, ss_n_s;

  // Pins cross from outside; all idle high
  ssim_sync #(.W(4), .RST(4'hf)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({scl_i, sda_i, sdi_i, ss_n_i}),
    .q({scl_s, sda_s, sdi_s, ss_n_s})
  );

  // Software-visible state
  logic smp_q, cke_q;             // Sample phase and clock edge
  logic en_q, spi_q;              // Port enable and mode
  logic start_req_q, restart_req_q, stop_req_q;
  logic write_collision_flag_q, irq_q, ack_q, bf_q;
  logic start_seen_q, stop_seen_q;
  logic [7:0] buf_q, baud_q;

  // Engine state
  ssim_pkg::ssim_state_t state_q, state_d;
  logic [1:0] qtr_q, qtr_d;       // Quarter within bit or condition step
  logic [3:0] bitn_q, bitn_d;     // Bit counter
  logic [7:0] sr_q, sr_d;         // Shift register
  logic [7:0] rx_q, rx_d;         // SPI receive shift
  logic [7:0] div_q;              // Quarter divider
  logic scl_o_d, scl_oe_d, sda_o_d, sda_oe_d;
  logic ack_d;
  logic scl_o_q, scl_oe_q, sda_o_q, sda_oe_q; // Pin registers feed the outputs

  // Engine events
  logic irq_set, bf_clr, spi_done, start_done, stop_done;
  logic clr_start, clr_restart, clr_stop;

  // APB registered answer
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;

  // Bus decode
  wire setup_acc = psel & penable & ~pready_q;
  wire access = psel & penable & pready_q;
  wire hit_status = paddr == addr_of(ssim_pkg::IDX_STATUS);
  wire hit_ctrl = paddr == addr_of(ssim_pkg::IDX_CTRL);
  wire hit_irq = paddr == addr_of(ssim_pkg::IDX_IRQ);
  wire hit_buf = paddr == addr_of(ssim_pkg::IDX_BUF);
  wire hit_baud = paddr == addr_of(ssim_pkg::IDX_BAUD);
  wire hit_any = hit_status | hit_ctrl | hit_irq | hit_buf | hit_baud;
  wire wr = access & pwrite;
  wire wr_status = wr & hit_status;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_irq = wr & hit_irq;
  wire wr_buf = wr & hit_buf;
  wire wr_baud = wr & hit_baud;

  // Engine at rest: idle, or holding the bus between bytes
  wire st_idle = state_q == ssim_pkg::ST_IDLE;
  wire st_hold = state_q == ssim_pkg::ST_HOLD;
  // Buffer accepted only when nothing is shifting
  wire buf_ok = en_q & (spi_q ? st_idle : st_hold);
  wire write_collision_flag_set = wr_buf & ~buf_ok;                  // see R2
  // Divider frozen while at rest, so SCL stays low in hold
  wire run = ~st_idle & ~st_hold;                    // see R13
  wire tick = run & (div_q == baud_q);

  // SPI launch and sample quarters
  wire [1:0] launch_qtr = cke_q ? ssim_pkg::Q2 : ssim_pkg::Q0;    // see R17
  wire [1:0] sample_qtr = smp_q ? 2'(launch_qtr + ssim_pkg::Q3)
                                : 2'(launch_qtr + ssim_pkg::Q2);   // see R14
  wire spi_sample = tick & (qtr_q == sample_qtr);
  wire [7:0] rx_nx = spi_sample ? {rx_q[6:0], sdi_s} : rx_q;
  // SPI reset: select high or port off
  wire spi_abort = spi_q & (ss_n_s | ~en_q);

  // Status read value; data/address bit reserved in master
  wire [7:0] status_rd = {smp_q, cke_q, 1'b0,                       // see R18
                          stop_seen_q & ~spi_q, start_seen_q & ~spi_q, // see R19
                          state_q == ssim_pkg::ST_BYTE, 1'b0, bf_q};
  wire [7:0] ctrl_rd = {write_collision_flag_q, 1'b0, en_q, spi_q, 1'b0,
                        stop_req_q, restart_req_q, start_req_q};
  wire [7:0] irq_rd = {6'h00, ack_q, irq_q};
  wire [7:0] rd_byte = hit_status ? status_rd :
                       hit_ctrl ? ctrl_rd :
                       hit_irq ? irq_rd :
                       hit_buf ? buf_q :
                       hit_baud ? baud_q : 8'h00;

  // Engine next state
  always_comb begin
    state_d = state_q;
    qtr_d = qtr_q;
    bitn_d = bitn_q;
    sr_d = sr_q;
    rx_d = rx_nx;
    scl_o_d = scl_o_q;
    scl_oe_d = scl_oe_q;
    sda_o_d = sda_o_q;
    sda_oe_d = sda_oe_q;
    ack_d = ack_q;
    irq_set = 1'b0;
    bf_clr = 1'b0;
    spi_done = 1'b0;
    start_done = 1'b0;
    stop_done = 1'b0;
    clr_start = 1'b0;
    clr_restart = 1'b0;
    clr_stop = 1'b0;
    if (tick) begin
      qtr_d = 2'(qtr_q + 2'h1);
    end
    case (state_q)
      ssim_pkg::ST_IDLE: begin
        // I2C floats both lines; SPI drives clock low and data only when the port is enabled
        scl_o_d = 1'b0;
        sda_o_d = spi_q ? sda_o_q : 1'b0;
        scl_oe_d = spi_q & en_q;
        sda_oe_d = spi_q & en_q;
        qtr_d = ssim_pkg::Q0;
        bitn_d = 4'h0;
        if (en_q & ~spi_q & start_req_q) begin
          state_d = ssim_pkg::ST_START;            // see R22
        end else if (buf_ok & wr_buf) begin
          // SPI: edge-set mode presents MSB before first clock
          state_d = ssim_pkg::ST_SPI;              // see R8
          sr_d = cke_q ? {pwdata[6:0], 1'b0} : pwdata[7:0];
          sda_o_d = cke_q ? pwdata[7] : sda_o_q;
        end
      end
      ssim_pkg::ST_START: begin
        // SDA falls with SCL high, then a hold quarter, then SCL low
        if (tick) begin
          case (qtr_q)
            ssim_pkg::Q0: sda_oe_d = 1'b1;         // see R5
            ssim_pkg::Q1: sda_oe_d = 1'b1;         // see R7
            default: begin
              scl_oe_d = 1'b1;
              irq_set = 1'b1;                      // see R5
              clr_start = 1'b1;                    // see R22
              start_done = 1'b1;
              state_d = ssim_pkg::ST_HOLD;
            end
          endcase
        end
      end
      ssim_pkg::ST_RESTART: begin
        // Release SDA, release SCL, SDA low, SCL low
        if (tick) begin
          case (qtr_q)
            ssim_pkg::Q0: sda_oe_d = 1'b0;
            ssim_pkg::Q1: scl_oe_d = 1'b0;
            ssim_pkg::Q2: begin
              // A stretching slave keeps the step waiting
              if (scl_s) begin
                sda_oe_d = 1'b1;                   // see R11
              end else begin
                qtr_d = qtr_q;
              end
            end
            default: begin
              scl_oe_d = 1'b1;
              irq_set = 1'b1;                      // see R12
              clr_restart = 1'b1;                  // see R11
              start_done = 1'b1;
              state_d = ssim_pkg::ST_HOLD;
            end
          endcase
        end
      end
      ssim_pkg::ST_STOP: begin
        // SDA low, release SCL, release SDA with SCL high
        if (tick) begin
          case (qtr_q)
            ssim_pkg::Q0: sda_oe_d = 1'b1;
            ssim_pkg::Q1: scl_oe_d = 1'b0;
            ssim_pkg::Q2: sda_oe_d = 1'b0;         // see R10
            default: begin
              irq_set = 1'b1;                      // see R12
              clr_stop = 1'b1;                     // see R10
              stop_done = 1'b1;
              state_d = ssim_pkg::ST_IDLE;
            end
          endcase
        end
      end
      ssim_pkg::ST_BYTE: begin
        // Eight data bits MSB first, then the acknowledge clock
        if (tick) begin
          case (qtr_q)
            ssim_pkg::Q0: begin
              sda_oe_d = (bitn_q == ssim_pkg::ACK_BIT) ? 1'b0 : ~sr_q[7]; // see R8
            end
            ssim_pkg::Q1: scl_oe_d = 1'b0;
            ssim_pkg::Q2: begin
              if (!scl_s) begin
                qtr_d = qtr_q;
              end else if (bitn_q == ssim_pkg::ACK_BIT) begin
                ack_d = sda_s;                     // see R4
              end
            end
            default: begin
              scl_oe_d = 1'b1;
              sr_d = {sr_q[6:0], 1'b0};
              bitn_d = 4'(bitn_q + 4'h1);
              if (bitn_q == ssim_pkg::LAST_DATA_BIT) begin
                bf_clr = 1'b1;                     // see R1
              end
              if (bitn_q == ssim_pkg::ACK_BIT) begin
                irq_set = 1'b1;                    // see R9
                sda_oe_d = 1'b0;                   // see R13
                state_d = ssim_pkg::ST_HOLD;
              end
            end
          endcase
        end
      end
      ssim_pkg::ST_HOLD: begin
        // Bus owned: SCL low, SDA held low after start or restart and floating after a byte, divider stopped
        scl_oe_d = 1'b1;                           // see R13
        qtr_d = ssim_pkg::Q0;
        bitn_d = 4'h0;
        if (buf_ok & wr_buf) begin
          state_d = ssim_pkg::ST_BYTE;             // see R8
          sr_d = pwdata[7:0];
        end else if (restart_req_q) begin
          state_d = ssim_pkg::ST_RESTART;
        end else if (stop_req_q) begin
          state_d = ssim_pkg::ST_STOP;
        end
      end
      ssim_pkg::ST_SPI: begin
        // Clock rises at Q0 and falls at Q2
        if (tick) begin
          if (qtr_q == ssim_pkg::Q0) begin
            scl_o_d = 1'b1;
          end
          if (qtr_q == ssim_pkg::Q2) begin
            scl_o_d = 1'b0;
          end
          if (qtr_q == launch_qtr) begin
            sda_o_d = sr_q[7];                     // see R17
            sr_d = {sr_q[6:0], 1'b0};
          end
          if (qtr_q == ssim_pkg::Q3) begin
            bitn_d = 4'(bitn_q + 4'h1);
            if (bitn_q == ssim_pkg::LAST_DATA_BIT) begin
              bf_clr = 1'b1;                       // see R1
              irq_set = 1'b1;
              spi_done = 1'b1;
              state_d = ssim_pkg::ST_IDLE;
            end
          end
        end
      end
      default: state_d = ssim_pkg::ST_IDLE;
    endcase
    // Port off releases the I2C lines at once
    if (~en_q & ~spi_q) begin
      state_d = ssim_pkg::ST_IDLE;
      scl_oe_d = 1'b0;
      sda_oe_d = 1'b0;
    end
    // SPI reset zeroes the bit counter and stops the transfer
    if (spi_abort) begin
      state_d = ssim_pkg::ST_IDLE;                 // see R20
      bitn_d = 4'h0;                               // see R20
      scl_o_d = 1'b0;
    end
  end

  // Engine registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ssim_pkg::ST_IDLE;
      qtr_q <= ssim_pkg::Q0;
      bitn_q <= 4'h0;
      sr_q <= 8'h00;
      rx_q <= 8'h00;
      scl_o_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_o_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      qtr_q <= qtr_d;
      bitn_q <= bitn_d;
      sr_q <= sr_d;
      rx_q <= rx_d;
      scl_o_q <= scl_o_d;
      scl_oe_q <= scl_oe_d;
      sda_o_q <= sda_o_d;
      sda_oe_q <= sda_oe_d;
      ack_q <= ack_d;
    end
  end

  // Quarter divider; restarts whenever the engine rests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else begin
      div_q <= (tick | ~run) ? 8'h00 : 8'(div_q + 8'h01);
    end
  end

  // Request bits: accepted only where legal, cleared when the condition ends
  wire req_start_ok = wr_ctrl & pwdata[ssim_pkg::CTRL_START] & st_idle
                      & pwdata[ssim_pkg::CTRL_EN] & ~pwdata[ssim_pkg::CTRL_SPI];
  wire req_restart_ok = wr_ctrl & pwdata[ssim_pkg::CTRL_RESTART] & st_hold & ~stop_req_q;
  wire req_stop_ok = wr_ctrl & pwdata[ssim_pkg::CTRL_STOP] & st_hold & ~restart_req_q;

  // Control register and requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      spi_q <= 1'b0;
      start_req_q <= 1'b0;
      restart_req_q <= 1'b0;
      stop_req_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        en_q <= pwdata[ssim_pkg::CTRL_EN];
        spi_q <= pwdata[ssim_pkg::CTRL_SPI];
      end
      start_req_q <= (start_req_q & ~clr_start) | req_start_ok;       // see R22
      restart_req_q <= (restart_req_q & ~clr_restart) | req_restart_ok; // see R11
      stop_req_q <= (stop_req_q & ~clr_stop) | req_stop_ok;           // see R10
      // Collision: only software clears it; a new collision wins
      write_collision_flag_q <= (write_collision_flag_q & ~(wr_ctrl & ~pwdata[ssim_pkg::CTRL_WRITE_COLLISION_FLAG])) | write_collision_flag_set; // see R2
    end
  end

  // Status, event flag, buffer and baud registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_q <= ssim_pkg::STATUS_RST[ssim_pkg::STAT_SMP];
      cke_q <= ssim_pkg::STATUS_RST[ssim_pkg::STAT_CKE];
      bf_q <= ssim_pkg::STATUS_RST[ssim_pkg::STAT_BF];
      start_seen_q <= ssim_pkg::STATUS_RST[ssim_pkg::STAT_START];
      stop_seen_q <= ssim_pkg::STATUS_RST[ssim_pkg::STAT_STOP];
      irq_q <= 1'b0;
      buf_q <= 8'h00;
      baud_q <= ssim_pkg::BAUD_RST;
    end else begin
      // Only the two mode bits take writes
      if (wr_status) begin
        smp_q <= pwdata[ssim_pkg::STAT_SMP];       // see R23
        cke_q <= pwdata[ssim_pkg::STAT_CKE];       // see R23
      end
      // Buffer full: load sets, end of eighth bit clears
      bf_q <= (bf_q & ~bf_clr) | (wr_buf & buf_ok);   // see R1
      start_seen_q <= (start_seen_q | start_done) & ~stop_done;
      stop_seen_q <= (stop_seen_q | stop_done) & ~start_done; // see R19
      // Event flag: hardware set wins over a software clear
      irq_q <= (irq_q & ~(wr_irq & ~pwdata[ssim_pkg::IRQ_FLAG])) | irq_set;
      // Rejected writes leave the buffer untouched
      if (wr_buf & buf_ok) begin
        buf_q <= pwdata[7:0];                      // see R2
      end else if (spi_done) begin
        buf_q <= rx_nx;
      end
      if (wr_baud) begin
        baud_q <= pwdata[7:0];
      end
    end
  end

  // APB answer one wait cycle after the access phase opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup_acc;
      pslverr_q <= setup_acc & ~hit_any;
      prdata_q <= (setup_acc & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Pad controls: slew limiting only for fast I2C
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_ctrl_en <= 1'b0;
      smbus_in_en <= 1'b0;
    end else begin
      slew_ctrl_en <= ~spi_q & ~smp_q;             // see R16
      smbus_in_en <= ~spi_q & cke_q;
    end
  end

  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign scl_o = scl_o_q;
  assign scl_oe = scl_oe_q;
  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;

endmodule
`default_nettype wire

/* File: sim/ssim_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// Bus and pin checks at the top ports
module ssim_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin drives and pad control
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic slew_ctrl_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Completed writes
  wire wr = psel && penable && pready && pwrite;
  wire wr_st = wr && paddr == {ssim_pkg::IDX_STATUS[9:0], 2'h0};
  wire wr_ct = wr && paddr == {ssim_pkg::IDX_CTRL[9:0], 2'h0};
  logic i2c_on_q; // Enabled, not SPI
  // Mode mirror; only APB can change it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_on_q <= 1'b0;
    end else if (wr_ct) begin
      i2c_on_q <= pwdata[5] && !pwdata[4];
    end
  end
  AST_APB_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("wait state wrong");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("stray pslverr");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  AST_OPEN_DRAIN: assert property (i2c_on_q |-> !scl_o && !sda_o)
    else $error("pin driven high");
  AST_START_HOLD: assert property ($rose(sda_oe) && !scl_oe
    |=> sda_oe throughout (!scl_oe ##[1:1000] scl_oe))
    else $error("start hold short");
  AST_STOP_IDLE: assert property ($fell(sda_oe) && !scl_oe
    |=> (!sda_oe && !scl_oe) [*3])
    else $error("bus busy after stop");
  AST_SLEW: assert property (wr_st && i2c_on_q
    |-> ##2 slew_ctrl_en == !$past(pwdata[7], 2))
    else $error("slew control wrong");
  // Main scenarios reached
  CV_START: cover property ($rose(sda_oe) && !scl_oe);
  CV_STOP: cover property ($fell(sda_oe) && !scl_oe);
  CV_SLVERR: cover property (pslverr);
endmodule
bind ssim_top ssim_properties u_props (.*);
`default_nettype wire

/* File: sim/ssim_slave_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Behavioural I2C slave on the resolved lines
module ssim_slave_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // Bench commands: refuse ack, stretch clock
  input wire logic nack,
  input wire logic stretch,
  // Pull-downs and capture
  output logic sda_pull,
  output logic scl_pull,
  output logic [7:0] rx_byte,
  output logic [7:0] n_stop
);
  logic scl_p; // Clock one cycle back
  logic sda_p; // Data one cycle back
  logic [3:0] bits; // Rising edges since start or since the last ninth clock
  logic [3:0] hold; // Stretch cycles left
  // Edges seen on the lines
  wire cond = scl && scl_p;
  wire rise = scl && !scl_p;
  wire fall = !scl && scl_p;
  assign scl_pull = hold != 4'h0;
  // Sampling, ack slot and stretching
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_p, sda_p, sda_pull} <= 3'h6;
      {bits, hold, rx_byte, n_stop} <= 24'h0;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
      if (cond && sda_p && !sda) begin
        bits <= 4'h0; // Start or restart
      end else if (cond && !sda_p && sda) begin
        n_stop <= n_stop + 8'h1; // Stop
      end else if (rise) begin
        rx_byte <= (bits < 4'h8) ? {rx_byte[6:0], sda} : rx_byte;
        bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
      end else if (fall) begin
        sda_pull <= (bits == 4'h8) && !nack; // Ninth slot only
      end
      if (fall && stretch) begin
        hold <= 4'hc; // Longer than a quarter
      end else if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/sync_serial_i2c_master_tx_test.sv */
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench
module sync_serial_i2c_master_tx_test;
  // Register table row: access and answer
  typedef struct packed {
    logic w;
    logic [11:0] idx;
    logic [7:0] d;
    logic [31:0] exp;
    logic err;
  } ssim_row_t;
  // Register indices
  localparam logic [11:0] I_ST = ssim_pkg::IDX_STATUS;
  localparam logic [11:0] I_CT = ssim_pkg::IDX_CTRL;
  localparam logic [11:0] I_IQ = ssim_pkg::IDX_IRQ;
  localparam logic [11:0] I_BU = ssim_pkg::IDX_BUF;
  localparam logic [11:0] I_BD = ssim_pkg::IDX_BAUD;
  // Bench drives
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic nack = 1'b0;
  logic stretch = 1'b0;
  // Design and peer outputs
  logic [31:0] prdata;
  logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, slew_ctrl_en;
  logic sda_pull, scl_pull;
  logic [7:0] rx_byte, n_stop;
  // Open-drain lines with pull-ups
  wire scl = !((scl_oe && !scl_o) || scl_pull);
  wire sda = !((sda_oe && !sda_o) || sda_pull);
  logic [31:0] rdv; // Last read data
  logic errv; // Last error flag
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  // Plain register cases
  ssim_row_t rows [11] = '{
    '{1'b0, I_ST, 8'h00, 32'h0, 1'b0},
    '{1'b0, I_CT, 8'h00, 32'h0, 1'b0},
    '{1'b0, I_IQ, 8'h00, 32'h0, 1'b0},
    '{1'b0, I_BD, 8'h00, 32'(ssim_pkg::BAUD_RST), 1'b0},
    '{1'b1, I_BD, 8'h03, 32'h0, 1'b0},
    '{1'b0, I_BD, 8'h00, 32'h3, 1'b0},
    '{1'b1, I_ST, 8'hff, 32'h0, 1'b0},
    '{1'b0, I_ST, 8'h00, 32'hc0, 1'b0},
    '{1'b1, I_ST, 8'h00, 32'h0, 1'b0},
    '{1'b0, 12'h194, 8'h00, 32'h0, 1'b1},
    '{1'b1, 12'h194, 8'h5a, 32'h0, 1'b1}
  };
  ssim_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .sdi_i(1'b1), .ss_n_i(1'b1),
    .slew_ctrl_en(slew_ctrl_en), .smbus_in_en());
  ssim_slave_model PEER (.*);
  // Register value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Single bit compare
  task automatic chkb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: bit %b want %b", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; held until pready, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 12'(idx << 2);
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) n_mismatch++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Poll the event flag, bounded
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      apb(1'b0, I_IQ, 8'h00);
      n++;
    end while (rdv[0] !== 1'b1 && n < 200);
    chkb(rdv[0], 1'b1);
  endtask
  // One byte with a refused reload in mid-shift
  task automatic send(input logic [7:0] d, input logic nk);
    nack <= nk;
    apb(1'b1, I_BU, d);
    apb(1'b0, I_ST, 8'h00);
    chkb(rdv[0], 1'b1);
    apb(1'b1, I_BU, ~d);
    apb(1'b0, I_BU, 8'h00);
    chk(rdv, {24'h0, d});
    apb(1'b0, I_CT, 8'h00);
    chkb(rdv[7], 1'b1);
    apb(1'b1, I_CT, 8'h20);
    wait_irq();
    chkb(rdv[1], nk);
    chk({24'h0, rx_byte}, {24'h0, d});
    apb(1'b0, I_ST, 8'h00);
    chkb(rdv[0], 1'b0);
    repeat (20) @(posedge pclk);
    chkb(scl, 1'b0);
    chkb(sda, 1'b1);
    apb(1'b1, I_IQ, 8'h00);
  endtask
  initial begin
    forever #10 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].d);
      chk(rdv, rows[i].exp);
      chkb(errv, rows[i].err);
    end
    apb(1'b1, I_CT, 8'h20);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, I_ST, {i[0], 7'h0});
      repeat (2) @(posedge pclk);
      chkb(slew_ctrl_en, !i[0]);
    end
    apb(1'b1, I_BU, 8'h11);
    apb(1'b0, I_CT, 8'h00);
    chk(rdv, 32'ha0);
    apb(1'b1, I_CT, 8'h20);
    apb(1'b0, I_CT, 8'h00);
    chk(rdv, 32'h20);
    apb(1'b1, I_CT, 8'h21);
    wait_irq();
    apb(1'b0, I_CT, 8'h00);
    chk(rdv, 32'h20);
    apb(1'b0, I_ST, 8'h00);
    chk(rdv, 32'h88);
    apb(1'b1, I_IQ, 8'h00);
    send(8'ha5, 1'b0);
    stretch <= 1'b1;
    send(8'h3c, 1'b1);
    stretch <= 1'b0;
    apb(1'b1, I_CT, 8'h22);
    wait_irq();
    apb(1'b0, I_CT, 8'h00);
    chk(rdv, 32'h20);
    apb(1'b1, I_IQ, 8'h00);
    send(8'h81, 1'b0);
    apb(1'b1, I_CT, 8'h24);
    wait_irq();
    apb(1'b0, I_CT, 8'h00);
    chk(rdv, 32'h20);
    apb(1'b0, I_ST, 8'h00);
    chk(rdv, 32'h90);
    chk({24'h0, n_stop}, 32'h1);
    chkb(scl && sda, 1'b1);
    // Reset again in mid-run
    apb(1'b1, I_ST, 8'hc0);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, I_ST, 8'h00);
    chk(rdv, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
